// ===== src/ref_ctrl_map.vh
// Register map, field positions, reset values and codes of ref input control
//
// Functional notes
// - Bypass bit routes reference around glitch-free mux
// - Keep-on clear: secondary buffer off after return
// - Keep-on set: secondary buffer stays on
// - Secondary buffer gain bit: 0 minimum, 1 maximum
// - Primary buffer gain bit: 0 minimum, 1 maximum
// - Pre-divider code 0 bypass, n divides n+1
// - Choice codes: auto, pin, primary, secondary
// - Pin low primary, mid secondary, high auto
`ifndef REF_CTRL_MAP_VH
`define REF_CTRL_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_REF_SELECT        8'h32
`define IDX_INPUT_REF_CTRL    8'h33
`define IDX_REF_PREDIVIDER    8'h34
`define IDX_REF_STATUS        8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_MUX_BYPASS        7
`define BIT_SEC_KEEP_ON       2
`define BIT_SEC_GAIN          1
`define BIT_PRI_GAIN          0
`define BIT_RSVD_HI           6
`define BIT_RSVD_LO           3
`define W_PREDIV              3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_INPUT_REF_CTRL    8'h03
`define RST_PREDIV            3'h0
`define RST_REF_CHOICE        2'h1

// ----------------------------------------------------------------
// Reference choice codes and pin levels
// ----------------------------------------------------------------
`define CHOICE_AUTO           2'h0
`define CHOICE_PIN            2'h1
`define CHOICE_PRI            2'h2
`define CHOICE_SEC            2'h3
`define PIN_LOW               2'h0
`define PIN_MID               2'h1

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define LOSS_CYCLES_DEFAULT   64

`endif

// ===== src/ref_predivider.v
// Reference pre-divider ahead of the PLL, driven by sampled reference level
`timescale 1ns/10ps
`include "ref_ctrl_map.vh"

module ref_predivider #(
    parameter W = `W_PREDIV                  // Ratio field width
) (
    input  wire         clk_sys,             // System clock
    input  wire         rst,                 // Async reset, active high
    input  wire         ref_level,           // Muxed reference level
    input  wire [W-1:0] ratio,               // Ratio code
    output reg          div_out              // Divided reference
);

    // ----------------------------------------------------------------
    // Edge detect and period counter
    // ----------------------------------------------------------------
    reg         ref_d_reg;                   // Previous reference level
    reg [W-1:0] cnt_reg;                     // Input period counter
    reg [W-1:0] act_reg;                     // Ratio in use
    wire        rise = ref_level & ~ref_d_reg;
    wire        wrap = rise & (cnt_reg >= act_reg);
    wire [W:0]  half = ({1'b0, act_reg} + {{W{1'b0}}, 1'b1}) >> 1;

    // Count reference periods; a new ratio is taken only at a wrap so a
    // ratio change never cuts an output pulse short
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ref_d_reg <= 1'b0;
            cnt_reg   <= {W{1'b0}};
            act_reg   <= {W{1'b0}};
        end else begin
            ref_d_reg <= ref_level;
            if (wrap) begin
                cnt_reg <= {W{1'b0}};      // Wrap after n+1 periods
                act_reg <= ratio;
            end else if (rise) begin
                cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Output: pass-through for code 0, else high for first half of cycle
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_out <= 1'b0;
        end else if (act_reg == {W{1'b0}}) begin
            div_out <= ref_level;
        end else begin
            div_out <= ({1'b0, cnt_reg} < half);
        end
    end

endmodule

// ===== src/reference_input_control.v
// Reference input control: APB registers, source select, glitch-free mux
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`include "ref_ctrl_map.vh"

module reference_input_control #(
    parameter ADDR_W      = 12,                    // APB address width
    parameter LOSS_CYCLES = `LOSS_CYCLES_DEFAULT   // Idle cycles for loss
) (
    input  wire              clk_sys,        // System clock
    input  wire              rst,            // Async reset, active high
    input  wire              psel,           // APB select
    input  wire              penable,        // APB enable
    input  wire              pwrite,         // APB direction
    input  wire [ADDR_W-1:0] paddr,          // APB byte address
    input  wire [31:0]       pwdata,         // APB write data
    output reg  [31:0]       prdata,         // APB read data
    output wire              pready,         // APB ready
    output wire              pslverr,        // APB error
    input  wire              pri_ref_in,     // Primary reference pin
    input  wire              sec_ref_in,     // Secondary reference pin
    input  wire [1:0]        ref_choice_pin, // Three-level pin comparator
    output reg               pll_ref_clk,    // Divided PLL reference
    output reg               pri_gain_max,   // Primary buffer max gain
    output reg               sec_gain_max,   // Secondary buffer max gain
    output reg               sec_buf_enable  // Secondary crystal buffer on
);

    // ----------------------------------------------------------------
    // State codes of the glitch-free switch
    // ----------------------------------------------------------------
    localparam [1:0] ST_RUN   = 2'h0;        // Connected to active source
    localparam [1:0] ST_DRAIN = 2'h1;        // Wait old source low
    localparam [1:0] ST_ARM   = 2'h2;        // Wait new source falling

    // Map a byte address to a register slot, 0 when unmapped
    function [2:0] slot;
        input [ADDR_W-1:0] a;
        begin
            if (a[1:0] != 2'b00) begin
                slot = 3'd0;
            end else if (a[ADDR_W-1:2] == `IDX_REF_SELECT) begin
                slot = 3'd1;
            end else if (a[ADDR_W-1:2] == `IDX_INPUT_REF_CTRL) begin
                slot = 3'd2;
            end else if (a[ADDR_W-1:2] == `IDX_REF_PREDIVIDER) begin
                slot = 3'd3;
            end else if (a[ADDR_W-1:2] == `IDX_REF_STATUS) begin
                slot = 3'd4;
            end else begin
                slot = 3'd0;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [7:0]           ctrl_reg;           // Input reference control
    reg  [`W_PREDIV-1:0] prediv_reg;         // Pre-divider ratio
    reg  [1:0]           choice_reg;         // Reference choice code
    wire [2:0]           wr_slot = slot(paddr);
    wire                 setup   = psel & ~penable;
    wire                 access  = psel & penable;
    wire                 wr_en   = access & pwrite;
    wire                 mux_bypass = ctrl_reg[`BIT_MUX_BYPASS];
    wire                 keep_on    = ctrl_reg[`BIT_SEC_KEEP_ON];

    assign pready  = 1'b1;                   // Zero wait states
    assign pslverr = access & (wr_slot == 3'd0) |
                     wr_en & (wr_slot == 3'd4);

    // Register writes, taken in the access phase
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_reg   <= `RST_INPUT_REF_CTRL;
            prediv_reg <= `RST_PREDIV;
            choice_reg <= `RST_REF_CHOICE;
        end else if (wr_en) begin
            case (wr_slot)
                3'd1: choice_reg <= pwdata[1:0];
                3'd2: ctrl_reg   <= pwdata[7:0];
                3'd3: prediv_reg <= pwdata[`W_PREDIV-1:0];
                default: ;                   // Read-only or unmapped
            endcase
        end
    end

    // Buffer gain controls follow their bits
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pri_gain_max <= 1'b1;
            sec_gain_max <= 1'b1;
        end else begin
            pri_gain_max <= ctrl_reg[`BIT_PRI_GAIN];
            sec_gain_max <= ctrl_reg[`BIT_SEC_GAIN];
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg       pri_m_reg, pri_s_reg, pri_d_reg;   // Primary sync chain
    reg       sec_m_reg, sec_s_reg, sec_d_reg;   // Secondary sync chain
    reg [1:0] pin_m_reg, pin_s_reg;              // Choice pin sync chain

    // Two flops per pin, third flop on each reference pin for edge detection
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pri_m_reg <= 1'b0;
            pri_s_reg <= 1'b0;
            pri_d_reg <= 1'b0;
            sec_m_reg <= 1'b0;
            sec_s_reg <= 1'b0;
            sec_d_reg <= 1'b0;
            pin_m_reg <= 2'h0;
            pin_s_reg <= 2'h0;
        end else begin
            pri_m_reg <= pri_ref_in;
            pri_s_reg <= pri_m_reg;
            pri_d_reg <= pri_s_reg;
            sec_m_reg <= sec_ref_in;
            sec_s_reg <= sec_m_reg;
            sec_d_reg <= sec_s_reg;
            pin_m_reg <= ref_choice_pin;
            pin_s_reg <= pin_m_reg;
        end
    end

    // ----------------------------------------------------------------
    // Activity monitors for automatic selection
    // ----------------------------------------------------------------
    localparam CW = 16;
    localparam [CW-1:0] LOSS = LOSS_CYCLES[CW-1:0];
    reg [CW-1:0] pri_idle_reg, sec_idle_reg;     // Cycles since last edge
    wire         pri_ok = (pri_idle_reg < LOSS);
    wire         sec_ok = (sec_idle_reg < LOSS);

    // Restart on each rising edge, saturate at the loss count
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pri_idle_reg <= LOSS;
            sec_idle_reg <= LOSS;
        end else begin
            if (pri_s_reg & ~pri_d_reg) begin
                pri_idle_reg <= {CW{1'b0}};
            end else if (pri_ok) begin
                pri_idle_reg <= pri_idle_reg + {{(CW-1){1'b0}}, 1'b1};
            end
            if (sec_s_reg & ~sec_d_reg) begin
                sec_idle_reg <= {CW{1'b0}};
            end else if (sec_ok) begin
                sec_idle_reg <= sec_idle_reg + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // ----------------------------------------------------------------
    // Target source decode (1 = secondary)
    // ----------------------------------------------------------------
    reg target_sec;                              // Wanted source

    // Decode the choice code and, when deferred, the pin level
    always @* begin
        target_sec = 1'b0;
        case (choice_reg)
            `CHOICE_PRI:  target_sec = 1'b0;
            `CHOICE_SEC:  target_sec = 1'b1;
            `CHOICE_PIN: begin
                if (pin_s_reg == `PIN_LOW) begin
                    target_sec = 1'b0;
                end else if (pin_s_reg == `PIN_MID) begin
                    target_sec = 1'b1;
                end else begin
                    target_sec = ~pri_ok & sec_ok;
                end
            end
            default:      target_sec = ~pri_ok & sec_ok;
        endcase
    end

    // ----------------------------------------------------------------
    // Glitch-free switch
    // ----------------------------------------------------------------
    reg [1:0] st_reg;                            // Switch state
    reg       active_sec_reg;                    // Connected source
    reg       mux_out_reg;                       // Muxed reference level
    wire      cur_lvl = active_sec_reg ? sec_s_reg : pri_s_reg;
    wire      new_lvl = target_sec ? sec_s_reg : pri_s_reg;
    wire      new_prv = target_sec ? sec_d_reg : pri_d_reg;

    // Gate output low across a change; connect only on low levels
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg         <= ST_RUN;
            active_sec_reg <= 1'b0;
            mux_out_reg    <= 1'b0;
        end else if (mux_bypass) begin
            st_reg         <= ST_RUN;
            active_sec_reg <= target_sec;
            mux_out_reg    <= new_lvl;
        end else begin
            case (st_reg)
                ST_RUN: begin
                    mux_out_reg <= cur_lvl;
                    if (target_sec != active_sec_reg) begin
                        st_reg <= ST_DRAIN;
                        mux_out_reg <= cur_lvl & mux_out_reg;
                    end
                end
                ST_DRAIN: begin
                    mux_out_reg <= cur_lvl & mux_out_reg;
                    if (~cur_lvl) begin
                        st_reg      <= ST_ARM;
                        mux_out_reg <= 1'b0;
                    end
                end
                ST_ARM: begin
                    mux_out_reg <= 1'b0;
                    // Connect on a falling edge so the low phase is whole
                    if (~new_lvl & new_prv) begin
                        active_sec_reg <= target_sec;
                        st_reg         <= ST_RUN;
                    end
                end
                default: begin
                    st_reg      <= ST_RUN;
                    mux_out_reg <= 1'b0;
                end
            endcase
        end
    end

    // Secondary crystal buffer power across a return to primary
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sec_buf_enable <= 1'b1;
        end else if (keep_on | active_sec_reg | target_sec) begin
            sec_buf_enable <= 1'b1;
        end else begin
            sec_buf_enable <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Pre-divider and output
    // ----------------------------------------------------------------
    wire div_out;                                // Divided reference

    ref_predivider #(
        .W         (`W_PREDIV)
    ) u_prediv (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ref_level (mux_out_reg),
        .ratio     (prediv_reg),
        .div_out   (div_out)
    );

    // Register the divided reference onto the pin
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pll_ref_clk <= 1'b0;
        end else begin
            pll_ref_clk <= div_out;
        end
    end

    // ----------------------------------------------------------------
    // Read data, captured in the setup phase
    // ----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup & ~pwrite) begin
            case (wr_slot)
                3'd1: prdata <= {30'h0, choice_reg};
                3'd2: prdata <= {24'h0, ctrl_reg};
                3'd3: prdata <= {29'h0, prediv_reg};
                3'd4: prdata <= {26'h0, st_reg, sec_ok, pri_ok,
                                 sec_buf_enable, active_sec_reg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// ===== test/ref_ctrl_monitor.sv
// Port checker for the reference input control block
`timescale 1ns/10ps
module ref_ctrl_monitor #(
    parameter ADDR_W      = 12,  // APB address width
    parameter LOSS_CYCLES = 64   // Idle cycles for loss
) (
    input wire              clk_sys,
    input wire              rst,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata,
    input wire              pready,
    input wire              pslverr,
    input wire [1:0]        ref_choice_pin,
    input wire              pll_ref_clk,
    input wire              pri_gain_max,
    input wire              sec_gain_max,
    input wire              sec_buf_enable
);
    // ------------------------------------------------------------
    // Register shadows rebuilt from completed APB writes
    // ------------------------------------------------------------
    wire       acc = psel && penable && pready;   // Access phase
    wire       map = paddr == 12'hc8 || paddr == 12'hcc
                  || paddr == 12'hd0 || paddr == 12'h100;
    reg  [7:0] ctrl_reg;                          // Control shadow
    reg  [1:0] choice_reg;                        // Choice shadow

    // Shadow update at the write edge
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_reg   <= 8'h03;
            choice_reg <= 2'h1;
        end else if (acc && pwrite && paddr == 12'hcc) begin
            ctrl_reg <= pwdata[7:0];
        end else if (acc && pwrite && paddr == 12'hc8) begin
            choice_reg <= pwdata[1:0];
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_gain_pri;
        pri_gain_max == $past(ctrl_reg[0]);
    endproperty
    a_gain_pri: assert property (p_gain_pri)
        else $error("Primary gain does not follow its bit");
    property p_gain_sec;
        sec_gain_max == $past(ctrl_reg[1]);
    endproperty
    a_gain_sec: assert property (p_gain_sec)
        else $error("Secondary gain does not follow its bit");
    property p_keep;
        ctrl_reg[2] [*3] |-> sec_buf_enable;
    endproperty
    a_keep: assert property (p_keep)
        else $error("Secondary buffer off while keep-on set");
    property p_drop;
        $fell(sec_buf_enable) |-> !$past(ctrl_reg[2]);
    endproperty
    a_drop: assert property (p_drop)
        else $error("Secondary buffer dropped with keep-on set");
    property p_sec;
        choice_reg == 2'h3 [*6] |-> sec_buf_enable;
    endproperty
    a_sec: assert property (p_sec)
        else $error("Forced secondary with buffer off");
    property p_pin_mid;
        (choice_reg == 2'h1 && ref_choice_pin == 2'h1) [*6]
            |-> sec_buf_enable;
    endproperty
    a_pin_mid: assert property (p_pin_mid)
        else $error("Pin mid level without secondary buffer");
    property p_runt_hi;
        $rose(pll_ref_clk) && !ctrl_reg[7] |=> pll_ref_clk [*2];
    endproperty
    a_runt_hi: assert property (p_runt_hi)
        else $error("Short high pulse on reference path");
    property p_runt_lo;
        $fell(pll_ref_clk) && !ctrl_reg[7] |=> !pll_ref_clk [*2];
    endproperty
    a_runt_lo: assert property (p_runt_lo)
        else $error("Short low pulse on reference path");
    property p_err;
        psel && penable |-> pready && (pslverr == (!map
            || (pwrite && paddr == 12'h100)));
    endproperty
    a_err: assert property (p_err)
        else $error("Wrong ready or error in access phase");
    property p_err_idle;
        !(psel && penable) |-> !pslverr;
    endproperty
    a_err_idle: assert property (p_err_idle)
        else $error("Error flag outside access phase");
endmodule

bind reference_input_control ref_ctrl_monitor #(.ADDR_W(ADDR_W),
    .LOSS_CYCLES(LOSS_CYCLES)) i_ref_ctrl_monitor (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .ref_choice_pin(ref_choice_pin),
    .pll_ref_clk(pll_ref_clk), .pri_gain_max(pri_gain_max),
    .sec_gain_max(sec_gain_max), .sec_buf_enable(sec_buf_enable));

// ===== test/reference_input_control_tb.sv
// Self-checking bench for the reference input control block
`timescale 1ns/10ps
module reference_input_control_tb;
    // ------------------------------------------------------------
    // Signals and model
    // ------------------------------------------------------------
    reg          clk_sys, rst, psel, penable, pwrite;
    reg  [11:0]  paddr;
    reg  [31:0]  pwdata;
    reg          pri_ref_in, sec_ref_in, pri_on, sec_on;
    reg  [1:0]   ref_choice_pin;
    wire [31:0]  prdata;
    wire         pready, pslverr, pll_ref_clk;
    wire         pri_gain_max, sec_gain_max, sec_buf_enable;
    int          error_cnt, cmp_count, pc, sc, n;
    logic [31:0] mdl [int];     // Register model by byte address
    logic [31:0] q, d;          // Read data, random data
    logic        e;             // Error response
    int          t_ch[8] = '{0, 1, 1, 1, 2, 3, 3, 2};
    int          t_pin[8] = '{0, 0, 1, 2, 0, 0, 0, 0};
    int          t_exp[8] = '{60, 60, 40, 60, 60, 40, 40, 60};

    reference_input_control #(.ADDR_W(12), .LOSS_CYCLES(16))
        i_reference_input_control (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pri_ref_in(pri_ref_in),
        .sec_ref_in(sec_ref_in), .ref_choice_pin(ref_choice_pin),
        .pll_ref_clk(pll_ref_clk), .pri_gain_max(pri_gain_max),
        .sec_gain_max(sec_gain_max), .sec_buf_enable(sec_buf_enable));

    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Sources: primary period 8, secondary 12 cycles; stopped stays low
    always @(posedge clk_sys) begin
        pc <= (pc == 3) ? 0 : pc + 1;
        sc <= (sc == 5) ? 0 : sc + 1;
        if (pc == 3) pri_ref_in <= pri_on & ~pri_ref_in;
        if (sc == 5) sec_ref_in <= sec_on & ~sec_ref_in;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_near(input int got, input int exp);
        cmp_count++;
        if (got < exp - 1 || got > exp + 1) begin
            error_cnt++;
            $display("ERROR t=%0t edges %0d expected %0d", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task apb(input bit w, input [11:0] a, input [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task wr(input [11:0] a, input [31:0] wd, input [31:0] m);
        apb(1'b1, a, wd);
        mdl[a] = wd & m;
    endtask

    // Read and compare data and error flag against the model
    task rd(input [11:0] a);
        apb(1'b0, a, 32'h0);
        chk(q, mdl.exists(a) ? mdl[a] : 32'h0);
        chk({31'h0, e}, {31'h0, !mdl.exists(a)});
    endtask

    // Count reference rising edges over 480 cycles after settling
    task edges(input [1:0] ch, input [1:0] pin);
        logic last;
        ref_choice_pin <= pin;
        wr(12'hc8, {30'h0, ch}, 32'h3);
        repeat (120) @(posedge clk_sys);
        n = 0;
        last = pll_ref_clk;
        repeat (480) begin
            @(posedge clk_sys);
            if (pll_ref_clk === 1'b1 && last === 1'b0) n++;
            last = pll_ref_clk;
        end
    endtask

    task print_verdict;
        $display("Comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk_sys);
        error_cnt++;
        print_verdict;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pri_ref_in, sec_ref_in, pri_on, sec_on} = 4'h3;
        {error_cnt, cmp_count, pc, sc} = '0;
        ref_choice_pin = 2'h0;
        n = $urandom(36337);
        mdl[12'hc8] = 32'h1;
        mdl[12'hcc] = 32'h3;
        mdl[12'hd0] = 32'h0;
        rst = 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(12'hcc);
        rd(12'hd0);
        rd(12'hc8);
        rd(12'hd4);
        rd(12'hcd);
        apb(1'b1, 12'h100, 32'hff);
        chk({31'h0, e}, 32'h1);
        // Random control values, bypass kept off
        repeat (6) begin
            d = $urandom & 32'h7f;
            wr(12'hcc, d, 32'hff);
            rd(12'hcc);
            chk({31'h0, pri_gain_max}, {31'h0, d[0]});
            chk({31'h0, sec_gain_max}, {31'h0, d[1]});
        end
        wr(12'hcc, 32'h3, 32'hff);
        // Every divider code on the primary source
        for (int k = 0; k < 8; k++) begin
            wr(12'hd0, 32'hfffffff8 | k, 32'h7);
            rd(12'hd0);
            edges(2'h2, 2'h0);
            chk_near(n, 60 / (k + 1));
        end
        wr(12'hd0, 32'h0, 32'h7);
        // Every choice code and pin level, then bypassed
        for (int k = 0; k < 8; k++) begin
            if (k == 6) wr(12'hcc, 32'h83, 32'hff);
            edges(t_ch[k][1:0], t_pin[k][1:0]);
            chk_near(n, t_exp[k]);
        end
        wr(12'hcc, 32'h3, 32'hff);
        pri_on <= 1'b0;
        edges(2'h0, 2'h0);
        chk_near(n, 40);
        pri_on <= 1'b1;
        edges(2'h0, 2'h0);
        chk_near(n, 60);
        // Return from secondary with keep-on clear and set
        for (int k = 0; k < 2; k++) begin
            wr(12'hcc, 32'h3 | (k << 2), 32'hff);
            edges(2'h3, 2'h0);
            chk({31'h0, sec_buf_enable}, 32'h1);
            edges(2'h2, 2'h0);
            chk({31'h0, sec_buf_enable}, k);
        end
        print_verdict;
    end
endmodule
